// ==== dv/atu_periph.sv ====
// peripheral model for the six channels of the transfer unit
// assumes registered select outputs on CLOCK; reply delay is drawn at random
module atu_periph (
   input  wire logic             CLOCK,    // store clock
   input  wire logic             RST,      // reset, active high
   input  wire logic [5:0]       GO,       // bench asks for transfers
   input  wire logic [5:0]       CT,       // bench raises control ready
   input  wire logic [5:0]       OSEL,     // output select
   input  wire logic [5:0]       ISEL,     // input select
   output logic      [5:0]       DATA_RDY, // data ready
   output logic      [5:0]       CTRL_RDY, // control ready, held until the bench drops it
   output logic      [5:0]       REPLY,    // reply
   output logic      [5:0][17:0] DIN       // input data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0]  w_ff [6];   // reply wait per channel
   logic [11:0] n_ff [6];   // input words so far
   logic [5:0]  isq_ff;     // last input select
   // ==========================================
   // handshake: reply after a random wait, drop once select falls
   always_ff @(posedge CLOCK or posedge RST) begin
      for (int c = 0; c < 6; c++) begin
         if (RST) begin
            REPLY[c] <= 1'b0;
            w_ff[c] <= 2'h0;
            n_ff[c] <= 12'h000;
            isq_ff[c] <= 1'b0;
         end else begin
            isq_ff[c] <= ISEL[c];
            if ((OSEL[c] || ISEL[c]) && !REPLY[c]) begin
               if (w_ff[c] == 2'h0) REPLY[c] <= 1'b1;
               else w_ff[c] <= w_ff[c] - 2'h1;
            end else if (!OSEL[c] && !ISEL[c] && REPLY[c]) begin
               REPLY[c] <= 1'b0;
               w_ff[c] <= 2'($urandom % 4);
            end
            if (isq_ff[c] && !ISEL[c]) n_ff[c] <= n_ff[c] + 12'h001;
         end
      end
   end
   // data is {channel, 0, word number}; inverted while released so stale values never match
   always_comb begin
      for (int c = 0; c < 6; c++) DIN[c] = (ISEL[c] || REPLY[c]) ? {3'(c), 3'h0, n_ff[c]} : ~{3'(c), 3'h0, n_ff[c]};
   end
   assign DATA_RDY = GO;
   assign CTRL_RDY = CT;
endmodule // atu_periph

// ==== dv/testbench.sv ====
// self-checking bench for the transfer unit: store model, instruction port, random sequences
// assumes atu_unit and atu_periph are compiled first
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK, RST, WR, RD, MEM_REQ, MEM_WE, INT_OUT;
   logic [12:0] ADDR;
   logic [17:0] WDATA, RDATA, MEM_WDATA, MEM_RDATA;
   logic [16:0] MEM_ADDR;
   logic [1:0] UNIT_SEL;
   logic [5:0] DATA_RDY, CTRL_RDY, REPLY, OSEL, ISEL, ADDR1, LAST, PRST, INT_CH, GO, CT, osq;
   logic [5:0][17:0] DIN, DOUT;
   logic [9:0] ADDR_HI;
   logic [11:0] EXT_IN;
   logic [17:0] mem [1024];
   logic [19:0] expq [6][$];
   int nc[6], nd[6], dr[6], st[6];
   int errors, comparisons, pulses, u;
   atu_unit i_atu_unit (.CLOCK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .MEM_REQ, .MEM_WE, .MEM_ADDR,
      .MEM_WDATA, .MEM_RDATA, .UNIT_SEL, .DATA_RDY, .CTRL_RDY, .REPLY, .DIN, .DOUT, .OSEL, .ISEL,
      .ADDR1, .ADDR_HI, .LAST, .PRST, .INT_CH, .EXT_IN, .INT_OUT);
   atu_periph i_atu_periph (.CLOCK, .RST, .GO, .CT, .OSEL, .ISEL, .DATA_RDY, .CTRL_RDY, .REPLY, .DIN);
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   // ==========================================
   // store: read data only while the request stands, else the inverse
   always @(posedge CLOCK) begin
      if (MEM_REQ && MEM_WE) mem[MEM_ADDR[9:0]] <= MEM_WDATA;
   end
   assign MEM_RDATA = (MEM_REQ && !MEM_WE) ? mem[MEM_ADDR[9:0]] : ~mem[MEM_ADDR[9:0]];
   // each new output select must match the next expected word
   always @(posedge CLOCK) begin
      osq <= OSEL;
      for (int c = 0; c < 6; c++) begin
         if (PRST[c]) pulses++;
         if (OSEL[c] && !osq[c]) begin
            if (expq[c].size() == 0) chk({ADDR1[c], LAST[c], DOUT[c]}, 20'hFFFFF);
            else chk({ADDR1[c], LAST[c], DOUT[c]}, expq[c].pop_front());
            chk(20'(ADDR_HI), 20'h0);
         end
      end
   end
   // ==========================================
   // tasks
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [12:0] a, input logic [17:0] d);
      @(posedge CLOCK);
      ADDR <= a + 13'(8 * u);
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   task automatic rdc(input logic [12:0] a, input logic [17:0] e);
      @(posedge CLOCK);
      ADDR <= a + 13'(8 * u);
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 chk(20'(RDATA), 20'(e));
   endtask
   function automatic int who(input logic [11:0] v);
      who = 0;
      for (int i = 11; i >= 0; i--) if (v[i]) who = i + 1;
   endfunction
   // fill the four channel words and the expected output words
   task automatic build(input int c);
      int p, dp, cp;
      p = 32 + 32 * u + 4 * c;
      dp = 256 + 32 * c;
      cp = 512 + 4 * c;
      mem[p] = {dr[c][0], 17'(dp)};
      mem[p + 1] = {2'h0, st[c][0], 1'b0, 2'(nc[c]), 12'(nd[c])};
      mem[p + 2] = 18'(cp);
      mem[p + 3] = 18'h3FFFF;
      for (int k = 0; k < 4; k++) {mem[cp + k], mem[dp + k]} = 36'({$urandom, $urandom});
      for (int k = 0; k < nc[c]; k++) expq[c].push_back({2'h2, mem[cp + k]});
      for (int k = 0; k < nd[c] && dr[c] != 0; k++) expq[c].push_back({1'b0, k == nd[c] - 1, mem[dp + k]});
   endtask
   // ==========================================
   // main sequence
   initial begin
      int lo, mk, a, b;
      logic [11:0] x;
      logic [19:0] x20;
      {RST, WR, RD, ADDR, WDATA, GO, CT, EXT_IN} = {1'b1, 57'h0};
      {errors, comparisons, pulses, mk} = 128'h0;
      void'($urandom(48442));
      u = $urandom % 4;
      UNIT_SEL = 2'(u);
      repeat (16) @(posedge CLOCK);
      RST <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk(20'({INT_CH, OSEL, ISEL}), 20'h0);
      for (int i = 0; i < 8; i++) begin
         x = 12'($urandom);
         EXT_IN <= x;
         a = (i == 0) ? 0 : $urandom;
         b = $urandom;
         wr(atu_pkg::OP_MSET, 18'(a));
         wr(atu_pkg::OP_MCLR, 18'(b));
         wr(13'h1484 + 13'(i % 4), 18'h3FFFF);
         mk = (mk | a) & ~b & 12'hFFF;
         rdc(atu_pkg::OP_RAW, 18'(x));
         rdc(atu_pkg::OP_WHO, 18'(who(x & 12'(mk))));
         rdc(13'h0485 + 13'(i % 3), 18'h0);
         chk(20'(INT_OUT), 20'(|(x & 12'(mk))));
      end
      for (int c = 0; c < 6; c++) begin
         {nc[c], nd[c], dr[c], st[c]} = {$urandom % 4, $urandom % 5, $urandom % 2, $urandom % 2};
         if (c == 0) {nc[c], nd[c], dr[c], st[c]} = {32'd3, 32'd4, 32'd1, 32'd1};
         if (c == 5) {nd[c], st[c]} = {32'd0, 32'd1};
         build(c);
         wr(atu_pkg::OP_INIT + 13'(c), 18'h0);
      end
      GO <= 6'h3F;
      for (lo = 0; lo < 5000 && INT_CH !== 6'h3F; lo++) @(posedge CLOCK);
      if (lo == 5000) begin
         errors++;
         complete_run;
      end
      for (int c = 0; c < 6; c++) begin
         for (int k = 0; k < nd[c] && dr[c] == 0; k++) chk(20'(mem[256 + 32 * c + k]), 20'({3'(c), 3'h0, 12'(k)}));
         chk(20'(mem[35 + 32 * u + 4 * c]), (st[c] != 0 && nd[c] != 0) ? 20'({3'(c), 3'h0, 12'(dr[c] ? 0 : nd[c])}) : 20'h3FFFF);
         rdc(atu_pkg::OP_RDADDR + 13'(c), {dr[c][0], 17'(256 + 32 * c + nd[c])});
         rdc(atu_pkg::OP_RDCNT + 13'(c), {2'h0, st[c][0] && nd[c] != 0, 15'h0});
         chk(20'(expq[c].size()), 20'h0);
      end
      build(0);
      wr(atu_pkg::OP_INIT, 18'h0);
      @(posedge CLOCK);
      #1 chk(20'(INT_CH), 20'h3E);
      repeat (6) @(posedge CLOCK);
      wr(atu_pkg::OP_TERM, 18'h0);
      @(posedge CLOCK);
      #1 expq[0].delete();
      repeat (200) @(posedge CLOCK);
      chk(20'(pulses), 20'h1);
      // control ready already up at initiation: one data word with last word, then end
      CT <= 6'h02;
      {nc[1], nd[1], dr[1], st[1]} = {32'd0, 32'd4, 32'd1, 32'd0};
      build(1);
      x20 = expq[1][0] | 20'h40000;
      expq[1].delete();
      expq[1].push_back(x20);
      wr(atu_pkg::OP_INIT + 13'h1, 18'h0);
      repeat (100) @(posedge CLOCK);
      chk(20'(INT_CH[1]), 20'h1);
      chk(20'(expq[1].size()), 20'h0);
      rdc(atu_pkg::OP_RDADDR + 13'h1, {1'b1, 17'(256 + 32 + 1)});
      rdc(atu_pkg::OP_RDCNT + 13'h1, 18'h00003);
      complete_run;
   end
endmodule // testbench

// ==== rtl/atu_pkg.sv ====
// constants, field layout and phase type for the six-channel transfer unit
// assumes one 100 MHz clock (CLOCK) and a store that answers reads in the same cycle as the request
package atu_pkg;
   localparam int          NCH          = 6;     // channels per unit
   localparam int          NEXT         = 12;    // interrupt extension inputs
   // instruction codes for the first unit
   localparam logic [12:0] OP_INIT      = 13'h14A0;  // 5280: initiate channel 1
   localparam logic [12:0] OP_TERM      = 13'h14C0;  // 5312: terminate channel 1
   localparam logic [12:0] OP_MSET      = 13'h1480;  // 5248: allow extension inputs
   localparam logic [12:0] OP_MCLR      = 13'h1481;  // 5249: prohibit extension inputs
   localparam logic [12:0] OP_RAW       = 13'h0480;  // 1152: raw extension inputs
   localparam logic [12:0] OP_WHO       = 13'h0481;  // 1153: lowest active input number
   localparam logic [12:0] OP_RDADDR    = 13'h04A0;  // 1184: address register channel 1
   localparam logic [12:0] OP_RDCNT     = 13'h04C0;  // 1216: count register channel 1
   localparam int          UNIT_OP_SH   = 3;     // code step of 8 per unit
   // store locations
   localparam logic [16:0] ST_BASE      = 17'h00020;  // channel 1 data pointer
   localparam int          UNIT_ST_SH   = 5;     // 32 words per unit
   localparam int          CH_ST_SH     = 2;     // 4 words per channel
   localparam logic [16:0] OFF_CNT      = 17'h00001;
   localparam logic [16:0] OFF_CPTR     = 17'h00002;
   localparam logic [16:0] OFF_STAT     = 17'h00003;
   // field positions (store bit n is index n-1)
   localparam int          AD_DIR       = 17;    // one = output
   localparam int          CNT_CTRL_LO  = 12;
   localparam int          CNT_CTRL_HI  = 13;
   localparam int          CNT_CYC      = 14;
   localparam int          CNT_STAT     = 15;
   localparam logic [11:0] CNT_ONE      = 12'h001;
   localparam logic [1:0]  CTRL_NONE    = 2'h0;

   // per-channel sequence phase
   typedef enum logic [3:0] {
      PH_IDLE, PH_INITC, PH_INITA, PH_CTRL, PH_LOADP, PH_DATA, PH_RELOAD, PH_STAT, PH_END
   } atu_phase_t;
endpackage

// ==== rtl/atu_unit.sv ====
// six-channel cycle-stealing transfer unit
// assumes a store that returns read data while MEM_REQ stands (cycle after the grant); peripheral pins are asynchronous
module atu_unit (
   input  wire logic                 CLOCK,       // 100 MHz store clock
   input  wire logic                 RST,         // asynchronous reset, active high
   input  wire logic [12:0]          ADDR,        // instruction code
   input  wire logic [17:0]          WDATA,       // accumulator in
   input  wire logic                 WR,          // instruction write strobe
   input  wire logic                 RD,          // readback strobe
   output logic      [17:0]          RDATA,       // accumulator out, cycle after RD
   output logic                      MEM_REQ,     // store request, one cycle
   output logic                      MEM_WE,      // store write
   output logic      [16:0]          MEM_ADDR,    // store address
   output logic      [17:0]          MEM_WDATA,   // store write data
   input  wire logic [17:0]          MEM_RDATA,   // store read data, in the MEM_REQ cycle
   input  wire logic [1:0]           UNIT_SEL,    // unit number strap, 0..3
   input  wire logic [5:0]           DATA_RDY,    // data ready per channel
   input  wire logic [5:0]           CTRL_RDY,    // control ready per channel
   input  wire logic [5:0]           REPLY,       // reply per channel
   input  wire logic [5:0][17:0]     DIN,         // data in per channel
   output logic      [5:0][17:0]     DOUT,        // output data register per channel
   output logic      [5:0]           OSEL,        // output select
   output logic      [5:0]           ISEL,        // input select
   output logic      [5:0]           ADDR1,       // address line 1
   output logic      [9:0]           ADDR_HI,     // address lines 2-11
   output logic      [5:0]           LAST,        // last word
   output logic      [5:0]           PRST,        // channel reset pulse
   output logic      [5:0]           INT_CH,      // channel interrupt requests
   input  wire logic [11:0]          EXT_IN,      // interrupt extension inputs
   output logic                      INT_OUT      // masked extension interrupt
);
   typedef struct packed {
      atu_pkg::atu_phase_t [5:0] phase;
      logic [5:0][17:0] addr, cnt, dout, din1, din2;
      logic [5:0]       osel, isel, a1, last, prst, intr, term, wait_rel;
      logic [5:0]       drdy1, drdy2, crdy1, crdy2, rep1, rep2;
      logic [11:0]      ext1, ext2, mask;
      logic [1:0]       unit1, unit2;
      logic [9:0]       a_hi;
      logic             int_out, busy, mem_req, mem_we;
      logic [2:0]       gch;
      logic [16:0]      mem_addr;
      logic [17:0]      mem_wdata, rdata;
   } atu_state_t;

   atu_state_t  q_ff, nxt_q;
   logic [5:0]  req, rdy, free, init_hit, term_hit;
   logic [12:0] code, idx;
   logic        is_mset, is_mclr, is_raw, found;
   logic [2:0]  g, win;
   logic [16:0] pb;
   logic [11:0] cdec;
   logic        endterm;
   logic        data_fin;
   logic [16:0] fin_addr;
   logic [11:0] fin_cnt;

   // base store location of a channel for this unit
   function automatic logic [16:0] pbase(input logic [1:0] u, input logic [2:0] c);
      return atu_pkg::ST_BASE + (17'(u) << atu_pkg::UNIT_ST_SH) + (17'(c) << atu_pkg::CH_ST_SH);
   endfunction

   // ==========================================================
   // next-state logic
   always_comb begin
      nxt_q    = q_ff;
      req      = '0;
      rdy      = '0;
      free     = '0;
      init_hit = '0;
      term_hit = '0;
      found    = 1'b0;
      win      = 3'h0;
      pb       = 17'h00000;
      cdec     = 12'h000;
      endterm  = 1'b0;
      g        = q_ff.gch;
      // two-flop synchronisers for the peripheral pins, the extension inputs and the strap
      nxt_q.drdy1 = DATA_RDY;
      nxt_q.drdy2 = q_ff.drdy1;
      nxt_q.crdy1 = CTRL_RDY;
      nxt_q.crdy2 = q_ff.crdy1;
      nxt_q.rep1  = REPLY;
      nxt_q.rep2  = q_ff.rep1;
      nxt_q.din1  = DIN;
      nxt_q.din2  = q_ff.din1;
      nxt_q.ext1  = EXT_IN;
      nxt_q.ext2  = q_ff.ext1;
      nxt_q.unit1 = UNIT_SEL;
      nxt_q.unit2 = q_ff.unit1;
      nxt_q.prst    = '0;
      nxt_q.rdata   = 18'h00000;
      nxt_q.mem_req = 1'b0;
      nxt_q.mem_we  = 1'b0;
      nxt_q.a_hi    = 10'h000;
      nxt_q.int_out = |(q_ff.ext2 & q_ff.mask);

      // per-channel peripheral handshake and request decode
      for (int i = 0; i < atu_pkg::NCH; i++) begin
         if (q_ff.osel[i] && q_ff.rep2[i]) begin
            nxt_q.osel[i]     = 1'b0;
            nxt_q.wait_rel[i] = 1'b1;
         end
         if (q_ff.wait_rel[i] && !q_ff.rep2[i])
            nxt_q.wait_rel[i] = 1'b0;
         rdy[i]  = q_ff.drdy2[i] | q_ff.crdy2[i];
         free[i] = !q_ff.osel[i] && !q_ff.isel[i] && !q_ff.wait_rel[i];
         case (q_ff.phase[i])
            atu_pkg::PH_INITC, atu_pkg::PH_INITA, atu_pkg::PH_LOADP, atu_pkg::PH_RELOAD:
               req[i] = 1'b1;
            atu_pkg::PH_CTRL:
               req[i] = rdy[i] && free[i];
            atu_pkg::PH_DATA: begin
               if (q_ff.crdy2[i] && free[i])
                  nxt_q.term[i] = 1'b1;
               if (q_ff.addr[i][atu_pkg::AD_DIR]) begin
                  req[i] = rdy[i] && free[i];
               end else begin
                  req[i] = q_ff.isel[i] && q_ff.rep2[i];
                  if (rdy[i] && free[i]) begin
                     nxt_q.isel[i] = 1'b1;
                     nxt_q.a1[i]   = 1'b0;
                     nxt_q.last[i] = (q_ff.cnt[i][11:0] == atu_pkg::CNT_ONE) || q_ff.term[i] ||
                                     q_ff.crdy2[i];
                  end
               end
            end
            atu_pkg::PH_STAT: begin
               req[i] = q_ff.isel[i] && q_ff.rep2[i];
               if (rdy[i] && free[i] && !q_ff.isel[i]) begin
                  nxt_q.isel[i] = 1'b1;
                  nxt_q.a1[i]   = 1'b1;
                  nxt_q.last[i] = 1'b0;
               end
            end
            atu_pkg::PH_END:
               if (rdy[i] && free[i]) begin
                  nxt_q.intr[i]  = 1'b1;
                  nxt_q.phase[i] = atu_pkg::PH_IDLE;
               end
            default: ;
         endcase
      end

      // ==========================================================
      // store cycle: grant on an idle cycle, finish on the busy one
      if (!q_ff.busy) begin
         for (int i = atu_pkg::NCH - 1; i >= 0; i--)
            if (req[i]) begin
               found = 1'b1;
               win   = 3'(i);
            end
         if (found) begin
            pb              = pbase(q_ff.unit2, win);
            nxt_q.busy      = 1'b1;
            nxt_q.mem_req   = 1'b1;
            nxt_q.gch       = win;
            nxt_q.mem_wdata = q_ff.din2[win];
            case (q_ff.phase[win])
               atu_pkg::PH_INITC, atu_pkg::PH_RELOAD:
                  nxt_q.mem_addr = pb + atu_pkg::OFF_CNT;
               atu_pkg::PH_INITA:
                  nxt_q.mem_addr = (q_ff.cnt[win][atu_pkg::CNT_CTRL_HI:atu_pkg::CNT_CTRL_LO] ==
                                    atu_pkg::CTRL_NONE) ? pb : pb + atu_pkg::OFF_CPTR;
               atu_pkg::PH_LOADP:
                  nxt_q.mem_addr = pb;
               atu_pkg::PH_STAT: begin
                  nxt_q.mem_addr = pb + atu_pkg::OFF_STAT;
                  nxt_q.mem_we   = 1'b1;
               end
               atu_pkg::PH_DATA: begin
                  nxt_q.mem_addr = q_ff.addr[win][16:0];
                  nxt_q.mem_we   = !q_ff.addr[win][atu_pkg::AD_DIR];
               end
               default:
                  nxt_q.mem_addr = q_ff.addr[win][16:0];
            endcase
         end
      end else begin
         nxt_q.busy = 1'b0;
         pb         = pbase(q_ff.unit2, g);
         cdec       = q_ff.cnt[g][11:0] - 12'h001;
         case (q_ff.phase[g])
            atu_pkg::PH_INITC: begin
               nxt_q.cnt[g]   = MEM_RDATA;
               nxt_q.phase[g] = atu_pkg::PH_INITA;
            end
            atu_pkg::PH_INITA, atu_pkg::PH_LOADP: begin
               nxt_q.addr[g] = MEM_RDATA;
               if (q_ff.phase[g] == atu_pkg::PH_INITA &&
                   q_ff.cnt[g][atu_pkg::CNT_CTRL_HI:atu_pkg::CNT_CTRL_LO] != atu_pkg::CTRL_NONE) begin
                  nxt_q.phase[g] = atu_pkg::PH_CTRL;
               end else if (q_ff.cnt[g][11:0] == 12'h000) begin
                  nxt_q.cnt[g][atu_pkg::CNT_CYC]  = 1'b0;
                  nxt_q.cnt[g][atu_pkg::CNT_STAT] = 1'b0;
                  nxt_q.phase[g] = atu_pkg::PH_END;
               end else begin
                  nxt_q.phase[g] = atu_pkg::PH_DATA;
               end
            end
            atu_pkg::PH_CTRL: begin
               nxt_q.dout[g]  = MEM_RDATA;
               nxt_q.osel[g]  = 1'b1;
               nxt_q.a1[g]    = 1'b1;
               nxt_q.last[g]  = 1'b0;
               nxt_q.addr[g][16:0] = q_ff.addr[g][16:0] + 17'h00001;
               nxt_q.cnt[g][atu_pkg::CNT_CTRL_HI:atu_pkg::CNT_CTRL_LO] =
                  q_ff.cnt[g][atu_pkg::CNT_CTRL_HI:atu_pkg::CNT_CTRL_LO] - 2'h1;
               if (q_ff.cnt[g][atu_pkg::CNT_CTRL_HI:atu_pkg::CNT_CTRL_LO] == 2'h1)
                  nxt_q.phase[g] = atu_pkg::PH_LOADP;
            end
            atu_pkg::PH_DATA: begin
               endterm = q_ff.term[g];
               if (q_ff.addr[g][atu_pkg::AD_DIR]) begin
                  nxt_q.dout[g] = MEM_RDATA;
                  nxt_q.osel[g] = 1'b1;
                  nxt_q.a1[g]   = 1'b0;
                  nxt_q.last[g] = (cdec == 12'h000) || endterm;
               end else begin
                  nxt_q.isel[g]     = 1'b0;
                  nxt_q.wait_rel[g] = 1'b1;
               end
               nxt_q.addr[g][16:0] = q_ff.addr[g][16:0] + 17'h00001;
               nxt_q.cnt[g][11:0]  = cdec;
               if (endterm) begin
                  nxt_q.term[g] = 1'b0;
                  nxt_q.cnt[g][atu_pkg::CNT_CYC] = 1'b0;
                  nxt_q.phase[g] = q_ff.cnt[g][atu_pkg::CNT_STAT] ? atu_pkg::PH_STAT : atu_pkg::PH_END;
               end else if (cdec == 12'h000) begin
                  if (q_ff.cnt[g][atu_pkg::CNT_CYC])
                     nxt_q.phase[g] = atu_pkg::PH_RELOAD;
                  else if (q_ff.cnt[g][atu_pkg::CNT_STAT])
                     nxt_q.phase[g] = atu_pkg::PH_STAT;
                  else
                     nxt_q.phase[g] = atu_pkg::PH_END;
               end
            end
            atu_pkg::PH_RELOAD: begin
               nxt_q.cnt[g]   = MEM_RDATA;
               nxt_q.phase[g] = atu_pkg::PH_LOADP;
            end
            atu_pkg::PH_STAT: begin
               nxt_q.isel[g]     = 1'b0;
               nxt_q.wait_rel[g] = 1'b1;
               nxt_q.phase[g]    = atu_pkg::PH_END;
            end
            default: ;
         endcase
      end

      // ==========================================================
      // instruction decode; applied last so it overrides a finishing grant
      code    = ADDR - 13'({q_ff.unit2, 3'h0});
      is_mset = WR && code == atu_pkg::OP_MSET;
      is_mclr = WR && code == atu_pkg::OP_MCLR;
      is_raw  = RD && code == atu_pkg::OP_RAW;
      if (is_mset)
         nxt_q.mask = q_ff.mask | WDATA[11:0];
      if (is_mclr)
         nxt_q.mask = q_ff.mask & ~WDATA[11:0];
      idx = code - atu_pkg::OP_INIT;
      if (WR && idx < 13'(atu_pkg::NCH))
         init_hit[idx[2:0]] = 1'b1;
      idx = code - atu_pkg::OP_TERM;
      if (WR && idx < 13'(atu_pkg::NCH))
         term_hit[idx[2:0]] = 1'b1;
      for (int i = 0; i < atu_pkg::NCH; i++) begin
         if (init_hit[i]) begin
            nxt_q.phase[i]    = atu_pkg::PH_INITC;
            nxt_q.intr[i]     = 1'b0;
            nxt_q.term[i]     = 1'b0;
            nxt_q.osel[i]     = 1'b0;
            nxt_q.isel[i]     = 1'b0;
            nxt_q.last[i]     = 1'b0;
         end
         if (term_hit[i]) begin
            nxt_q.phase[i] = atu_pkg::PH_IDLE;
            nxt_q.prst[i]  = 1'b1;
            nxt_q.osel[i]  = 1'b0;
            nxt_q.isel[i]  = 1'b0;
            nxt_q.last[i]  = 1'b0;
            nxt_q.term[i]  = 1'b0;
         end
      end
      // readback; unknown codes read zero and change nothing
      if (is_raw)
         nxt_q.rdata = {6'h00, q_ff.ext2};
      if (RD && code == atu_pkg::OP_WHO)
         for (int i = atu_pkg::NEXT - 1; i >= 0; i--)
            if (q_ff.ext2[i] && q_ff.mask[i])
               nxt_q.rdata = {14'h0000, 4'(i + 1)};
      idx = code - atu_pkg::OP_RDADDR;
      if (RD && idx < 13'(atu_pkg::NCH))
         nxt_q.rdata = q_ff.addr[idx[2:0]];
      idx = code - atu_pkg::OP_RDCNT;
      if (RD && idx < 13'(atu_pkg::NCH))
         nxt_q.rdata = q_ff.cnt[idx[2:0]];
   end

   // state register
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST)
         q_ff <= '0;
      else
         q_ff <= nxt_q;
   end

   // outputs straight from the state register
   assign RDATA     = q_ff.rdata;
   assign MEM_REQ   = q_ff.mem_req;
   assign MEM_WE    = q_ff.mem_we;
   assign MEM_ADDR  = q_ff.mem_addr;
   assign MEM_WDATA = q_ff.mem_wdata;
   assign DOUT      = q_ff.dout;
   assign OSEL      = q_ff.osel;
   assign ISEL      = q_ff.isel;
   assign ADDR1     = q_ff.a1;
   assign ADDR_HI   = q_ff.a_hi;
   assign LAST      = q_ff.last;
   assign PRST      = q_ff.prst;
   assign INT_CH    = q_ff.intr;
   assign INT_OUT   = q_ff.int_out;

   // channel finishing a store cycle, seen by the step checks below
   assign data_fin = q_ff.busy && q_ff.phase[q_ff.gch] == atu_pkg::PH_DATA;
   assign fin_addr = q_ff.addr[q_ff.gch][16:0];
   assign fin_cnt  = q_ff.cnt[q_ff.gch][11:0];

   // ==========================================================
   // assertions
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   one_grant_a: assert property (MEM_REQ |=> !MEM_REQ)
      else $error("store granted on consecutive cycles");
   prio_grant_a: assert property (MEM_REQ |-> ($past(req) & ((6'h01 << q_ff.gch) - 6'h01)) == 6'h00)
      else $error("lower channel was passed over");
   grant_req_a: assert property (MEM_REQ |-> (($past(req) >> q_ff.gch) & 6'h01) != 6'h00)
      else $error("grant without request");
   mask_set_a: assert property (is_mset |=> (q_ff.mask & $past(WDATA[11:0])) == $past(WDATA[11:0]))
      else $error("mask bits not set");
   mask_clr_a: assert property (is_mclr |=> (q_ff.mask & $past(WDATA[11:0])) == 12'h000)
      else $error("mask bits not cleared");
   raw_read_a: assert property (is_raw |=> RDATA == {6'h00, $past(q_ff.ext2)} ##1 ($past(RD) || RDATA == 18'h00000))
      else $error("raw extension readback wrong");
   term_stop_a: assert property (|term_hit |=> PRST == $past(term_hit) && ((OSEL | ISEL) & PRST) == 6'h00)
      else $error("terminate did not stop channel");
   int_clear_a: assert property (|init_hit |=> (INT_CH & $past(init_hit)) == 6'h00)
      else $error("initiate left interrupt set");
   addr_hi_a: assert property (ADDR_HI == 10'h000 && (ADDR1 & LAST) == 6'h00)
      else $error("address lines or last word wrong");
   int_out_a: assert property (##1 INT_OUT == |($past(q_ff.ext2) & $past(q_ff.mask)))
      else $error("extension interrupt mismatch");
   // a granted data word moves the address up and the count down by one
   addr_step_a: assert property (data_fin |=> fin_addr == $past(fin_addr) + 17'h00001)
      else $error("address did not step after data word");
   count_step_a: assert property (data_fin |=> fin_cnt == $past(fin_cnt) - 12'h001)
      else $error("count did not step after data word");
   rd_idle_a: assert property (!RD |=> RDATA == 18'h00000)
      else $error("readback data without read strobe");

   grant_c: cover property (MEM_REQ && MEM_WE);
   last_c: cover property ($rose(OSEL[0]) && LAST[0]);
   intr_c: cover property ($rose(INT_CH[1]));
   term_c: cover property (|PRST);
   stat_c: cover property (MEM_REQ && MEM_WE && ADDR1[q_ff.gch]);
endmodule // atu_unit
